// file: rtl/scg_pkg.sv
// constants for the sleep and deep-sleep peripheral clock gating block
package scg_pkg;
  // ==========================================================
  // register map (byte offsets from the system control base)
  localparam logic [31:0] BASE_ADDR      = 32'h400FE000;
  localparam logic [11:0] RUN_GATE_OFS   = 12'h104;
  localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
  localparam logic [11:0] DEEP_GATE_OFS  = 12'h124;
  localparam logic [11:0] RUN_CFG_OFS    = 12'h060;
  localparam logic [11:0] PWR_MODE_OFS   = 12'h200;
  // ==========================================================
  // field layout
  localparam logic [31:0] GATE_WMASK     = 32'h000F1033;
  localparam logic [31:0] GATE_RESET     = 32'h00000000;
  localparam int          AUTO_GATE_BIT  = 11;
  localparam logic [31:0] RUN_CFG_WMASK  = 32'h00000800;
  localparam logic [31:0] RUN_CFG_RESET  = 32'h00000000;
  localparam int          NUM_UNITS      = 9;
  localparam int          ASYNC_A_BIT    = 0;
  localparam int          ASYNC_B_BIT    = 1;
  localparam int          SYNC_A_BIT     = 4;
  localparam int          SYNC_B_BIT     = 5;
  localparam int          TWI_BIT        = 12;
  localparam int          TMR0_BIT       = 16;
  localparam int          TMR1_BIT       = 17;
  localparam int          TMR2_BIT       = 18;
  localparam int          TMR3_BIT       = 19;
  // ==========================================================
  // power modes
  typedef enum logic [1:0]
  {
    PM_RUN,
    PM_SLEEP,
    PM_DEEP
  } scg_mode_t;
endpackage : scg_pkg

// file: rtl/scg_gate.sv
// sleep and deep-sleep peripheral clock gating with APB register file
`timescale 1ns/1ps

// How it works
// - a one gating bit clocks its peripheral; zero leaves it unclocked
// - access to an unclocked peripheral answers with a bus fault
// - deep-sleep gating register resets to all zero
// - reserved bits read zero and ignore writes; software preserves them
// - run, sleep and deep-sleep registers share one layout
// - sleep and deep-sleep registers apply only with auto gating set
// - bits 19..16 gate timers 3, 2, 1 and 0
// - bit 12 gates the two-wire serial controller
// - bits 5 and 4 gate synchronous serial ports 1 and 0
// - bits 1 and 0 gate asynchronous serial ports 1 and 0
// - deep-sleep register decodes at offset 0x124
module scg_gate
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // power mode request from the core
  input  wire logic        sleep_req,
  input  wire logic        deep_req,
  // peripheral clock enables
  output logic             gp_counter_a_gate,
  output logic             gp_counter_b_gate,
  output logic             gp_counter_c_gate,
  output logic             gp_counter_d_gate,
  output logic             two_wire_port_gate,
  output logic             sync_serial_a_gate,
  output logic             sync_serial_b_gate,
  output logic             async_serial_a_gate,
  output logic             async_serial_b_gate,
  // peripheral bus access monitor
  input  wire logic        periph_access,
  input  wire logic [31:0] periph_sel,
  output logic             periph_fault
);

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge_w(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb,
                                          input logic [31:0] wmask);
    logic [31:0] lane;
    lane = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge_w = (old_v & ~(lane & wmask)) | (new_v & lane & wmask);
  endfunction : merge_w

  // one register address compare, shared by decode and checks
  function automatic logic at_ofs(input logic [11:0] addr,
                                  input logic [11:0] ofs);
    at_ofs = (addr == ofs);
  endfunction : at_ofs

  // ==========================================================
  // state
  logic [31:0]        run_gate_q;
  logic [31:0]        sleep_gate_q;
  logic [31:0]        deep_gate_q;
  logic [31:0]        run_cfg_q;
  logic [31:0]        active_d;
  logic [31:0]        active_q;
  scg_pkg::scg_mode_t mode_q;
  logic               wr_en;
  logic               rd_en;
  logic               hit;
  logic               auto_gate;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign hit = at_ofs(paddr, scg_pkg::RUN_GATE_OFS)
            || at_ofs(paddr, scg_pkg::SLEEP_GATE_OFS)
            || at_ofs(paddr, scg_pkg::DEEP_GATE_OFS)
            || at_ofs(paddr, scg_pkg::RUN_CFG_OFS)
            || at_ofs(paddr, scg_pkg::PWR_MODE_OFS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign auto_gate = run_cfg_q[scg_pkg::AUTO_GATE_BIT];

  // ==========================================================
  // gating registers, identical layout
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_gate_q   <= scg_pkg::GATE_RESET;
      sleep_gate_q <= scg_pkg::GATE_RESET;
      deep_gate_q  <= scg_pkg::GATE_RESET;
    end
    else if (wr_en)
    begin
      // reserved bits are masked off on write
      if (paddr == scg_pkg::RUN_GATE_OFS)
        run_gate_q <= merge_w(run_gate_q, pwdata, pstrb,
                              scg_pkg::GATE_WMASK);
      if (paddr == scg_pkg::SLEEP_GATE_OFS)
        sleep_gate_q <= merge_w(sleep_gate_q, pwdata, pstrb,
                                scg_pkg::GATE_WMASK);
      if (paddr == scg_pkg::DEEP_GATE_OFS)
        deep_gate_q <= merge_w(deep_gate_q, pwdata, pstrb,
                               scg_pkg::GATE_WMASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_cfg_q <= scg_pkg::RUN_CFG_RESET;
    else if (wr_en && paddr == scg_pkg::RUN_CFG_OFS)
      run_cfg_q <= merge_w(run_cfg_q, pwdata, pstrb,
                           scg_pkg::RUN_CFG_WMASK);
  end

  // ==========================================================
  // power mode tracking, deep-sleep wins over sleep
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode_q <= scg_pkg::PM_RUN;
    else if (deep_req)
      mode_q <= scg_pkg::PM_DEEP;
    else if (sleep_req)
      mode_q <= scg_pkg::PM_SLEEP;
    else
      mode_q <= scg_pkg::PM_RUN;
  end

  // ==========================================================
  // register selection per mode
  always_comb
  begin
    active_d = run_gate_q;
    case (mode_q)
      scg_pkg::PM_RUN:   active_d = run_gate_q;
      scg_pkg::PM_SLEEP: if (auto_gate) active_d = sleep_gate_q;
      scg_pkg::PM_DEEP:  if (auto_gate) active_d = deep_gate_q;
      default:           active_d = run_gate_q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_q <= scg_pkg::GATE_RESET;
    else
      active_q <= active_d & scg_pkg::GATE_WMASK;
  end

  // clock enables to each peripheral
  assign gp_counter_a_gate   = active_q[scg_pkg::TMR0_BIT];
  assign gp_counter_b_gate   = active_q[scg_pkg::TMR1_BIT];
  assign gp_counter_c_gate   = active_q[scg_pkg::TMR2_BIT];
  assign gp_counter_d_gate   = active_q[scg_pkg::TMR3_BIT];
  assign two_wire_port_gate  = active_q[scg_pkg::TWI_BIT];
  assign sync_serial_a_gate  = active_q[scg_pkg::SYNC_A_BIT];
  assign sync_serial_b_gate  = active_q[scg_pkg::SYNC_B_BIT];
  assign async_serial_a_gate = active_q[scg_pkg::ASYNC_A_BIT];
  assign async_serial_b_gate = active_q[scg_pkg::ASYNC_B_BIT];

  // ==========================================================
  // bus fault on access to an unclocked unit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      periph_fault <= 1'b0;
    else
      periph_fault <= periph_access
                   && ((periph_sel & scg_pkg::GATE_WMASK) != 32'h00000000)
                   && ((periph_sel & ~active_q & scg_pkg::GATE_WMASK)
                       != 32'h00000000);
  end

  // ==========================================================
  // read data, reserved bits read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        scg_pkg::RUN_GATE_OFS:   prdata <= run_gate_q;
        scg_pkg::SLEEP_GATE_OFS: prdata <= sleep_gate_q;
        scg_pkg::DEEP_GATE_OFS:  prdata <= deep_gate_q;
        scg_pkg::RUN_CFG_OFS:    prdata <= run_cfg_q;
        scg_pkg::PWR_MODE_OFS:   prdata <= {12'h000, active_q[19:16],
                                            3'h0, active_q[12], 6'h00,
                                            active_q[5:4], 2'h0,
                                            active_q[1:0]};
        default:                 prdata <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================
  // checks
  chk_deep_reset_zero: assert property (@(posedge pclk)
    $rose(presetn) |-> deep_gate_q == 32'h00000000)
    else $error("deep gate not zero after reset");

  chk_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (deep_gate_q & ~scg_pkg::GATE_WMASK) == 32'h00000000 &&
    (sleep_gate_q & ~scg_pkg::GATE_WMASK) == 32'h00000000)
    else $error("reserved gate bit set");

  chk_deep_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_en && paddr == scg_pkg::DEEP_GATE_OFS && pstrb == 4'hF |=>
    deep_gate_q == ($past(pwdata) & scg_pkg::GATE_WMASK))
    else $error("deep gate write lost");

  chk_deep_applied: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == scg_pkg::PM_DEEP && auto_gate |=>
    active_q == ($past(deep_gate_q) & scg_pkg::GATE_WMASK))
    else $error("deep gate not applied");

  chk_sleep_applied: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == scg_pkg::PM_SLEEP && auto_gate |=>
    active_q == ($past(sleep_gate_q) & scg_pkg::GATE_WMASK))
    else $error("sleep gate not applied");

  chk_run_fallback: assert property (@(posedge pclk) disable iff (!presetn)
    !auto_gate |=>
    active_q == ($past(run_gate_q) & scg_pkg::GATE_WMASK))
    else $error("run gate not applied");

  chk_timer_map: assert property (@(posedge pclk) disable iff (!presetn)
    {gp_counter_d_gate, gp_counter_c_gate, gp_counter_b_gate,
     gp_counter_a_gate} == active_q[19:16] &&
    two_wire_port_gate == active_q[12])
    else $error("timer gate map wrong");

  chk_serial_map: assert property (@(posedge pclk) disable iff (!presetn)
    {sync_serial_b_gate, sync_serial_a_gate, async_serial_b_gate,
     async_serial_a_gate} == {active_q[5:4], active_q[1:0]})
    else $error("serial gate map wrong");

  chk_fault_gated: assert property (@(posedge pclk) disable iff (!presetn)
    periph_access &&
    ((periph_sel & ~active_q & scg_pkg::GATE_WMASK) != 32'h00000000)
    |=> periph_fault)
    else $error("no fault on gated access");

  // ==========================================================
  // mode entry: a request moves the mode at the next edge and
  // the gate word one edge after that
  sequence s_enter_deep;
    deep_req ##1 auto_gate;
  endsequence

  sequence s_enter_sleep;
    !deep_req && sleep_req ##1 auto_gate;
  endsequence

  sequence s_enter_run;
    !deep_req && !sleep_req ##1 1'b1;
  endsequence

  chk_deep_entry: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_enter_deep |=> active_q == ($past(deep_gate_q) & scg_pkg::GATE_WMASK))
    else $error("deep gates not taken on entry");

  chk_sleep_entry: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_enter_sleep |=> active_q == ($past(sleep_gate_q) & scg_pkg::GATE_WMASK))
    else $error("sleep gates not taken on entry");

  chk_run_entry: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_enter_run |=> active_q == ($past(run_gate_q) & scg_pkg::GATE_WMASK))
    else $error("run gates not taken on entry");

  chk_mode_deep: assert property (
    @(posedge pclk) disable iff (!presetn)
    deep_req |=> mode_q == scg_pkg::PM_DEEP)
    else $error("deep request not tracked");

  chk_mode_sleep: assert property (
    @(posedge pclk) disable iff (!presetn)
    !deep_req && sleep_req |=> mode_q == scg_pkg::PM_SLEEP)
    else $error("sleep request not tracked");

  // ==========================================================
  // register bus behaviour
  chk_mapped_ok: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && at_ofs(paddr, scg_pkg::DEEP_GATE_OFS) |-> !pslverr)
    else $error("error on deep gate access");

  chk_read_deep: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && at_ofs(paddr, scg_pkg::DEEP_GATE_OFS)
    |=> prdata == $past(deep_gate_q))
    else $error("deep gate read wrong");

  chk_read_rsv: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite |->
    (prdata & ~scg_pkg::GATE_WMASK & ~scg_pkg::RUN_CFG_WMASK) == 32'h00000000)
    else $error("reserved bit read nonzero");

  chk_strobe_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && pstrb == 4'h0 |=>
    $stable(deep_gate_q) && $stable(sleep_gate_q) && $stable(run_gate_q))
    else $error("unstrobed write changed a gate");

  chk_status_ro: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && at_ofs(paddr, scg_pkg::PWR_MODE_OFS) |=>
    $stable(deep_gate_q) && $stable(sleep_gate_q) && $stable(run_gate_q))
    else $error("status write changed a gate");

  chk_cfg_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && at_ofs(paddr, scg_pkg::RUN_CFG_OFS) && pstrb[1] |=>
    auto_gate == $past(pwdata[scg_pkg::AUTO_GATE_BIT]))
    else $error("auto gating bit write lost");

  chk_sleep_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && at_ofs(paddr, scg_pkg::SLEEP_GATE_OFS) && pstrb == 4'hF |=>
    sleep_gate_q == ($past(pwdata) & scg_pkg::GATE_WMASK))
    else $error("sleep gate write lost");

  chk_run_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_en && at_ofs(paddr, scg_pkg::RUN_GATE_OFS) && pstrb == 4'hF |=>
    run_gate_q == ($past(pwdata) & scg_pkg::GATE_WMASK))
    else $error("run gate write lost");

  chk_status_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && at_ofs(paddr, scg_pkg::PWR_MODE_OFS)
    |=> prdata == $past(active_q))
    else $error("status read wrong");

  // ==========================================================
  // fault and reset behaviour
  chk_no_fault: assert property (
    @(posedge pclk) disable iff (!presetn)
    periph_access &&
    ((periph_sel & ~active_q & scg_pkg::GATE_WMASK) == 32'h00000000)
    |=> !periph_fault)
    else $error("fault on clocked access");

  chk_fault_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    !periph_access |=> !periph_fault)
    else $error("fault without access");

  chk_gates_reset: assert property (
    @(posedge pclk)
    !presetn |-> active_q == 32'h00000000 && !periph_fault)
    else $error("gates active in reset");

endmodule : scg_gate

// file: testbench/scg_gate_tb_top.sv
// self-checking bench for the sleep and deep-sleep clock gating block
`timescale 1ns/1ps
module scg_gate_tb_top;
  // ==========================================================
  // signals
  typedef struct {logic [11:0] a; logic [31:0] d; logic [3:0] s;
                  logic [31:0] r; logic e;} scg_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, sleep_req = 1'b0, deep_req = 1'b0;
  logic        periph_access = 1'b0, pready, pslverr, periph_fault;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, periph_sel = 32'h00000000, prdata;
  logic [3:0]  pstrb = 4'hF;
  logic        ga, gb, gc, gd, tw, sa, sb, aa, ab, er;
  logic [31:0] gw, rd;
  int          mismatches = 0, n_tests = 0;
  int          bits [9] = '{0, 1, 4, 5, 12, 16, 17, 18, 19};
  scg_row_t    rows [7];
  assign gw = {12'h000, gd, gc, gb, ga, 3'h0, tw, 6'h00,
               sb, sa, 2'h0, ab, aa};
  always #4 pclk = ~pclk;
  scg_gate uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .deep_req(deep_req), .gp_counter_a_gate(ga),
    .gp_counter_b_gate(gb), .gp_counter_c_gate(gc), .gp_counter_d_gate(gd),
    .two_wire_port_gate(tw), .sync_serial_a_gate(sa),
    .sync_serial_b_gate(sb), .async_serial_a_gate(aa),
    .async_serial_b_gate(ab), .periph_access(periph_access),
    .periph_sel(periph_sel), .periph_fault(periph_fault));
  // ==========================================================
  // tasks
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  task end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // ==========================================================
  // tests
  initial
  begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    end_sim();
  end
  initial
  begin
    rows[0] = '{scg_pkg::DEEP_GATE_OFS, 32'hFFFFFFFF, 4'hF, 32'h000F1033,
                1'b0};
    rows[1] = '{scg_pkg::SLEEP_GATE_OFS, 32'hFFFFFFFF, 4'hF, 32'h000F1033,
                1'b0};
    rows[2] = '{scg_pkg::RUN_GATE_OFS, 32'h12345678, 4'hF, 32'h00041030,
                1'b0};
    rows[3] = '{scg_pkg::RUN_CFG_OFS, 32'hFFFFFFFF, 4'hF, 32'h00000800,
                1'b0};
    rows[4] = '{scg_pkg::DEEP_GATE_OFS, 32'h00000000, 4'h0, 32'h000F1033,
                1'b0};
    rows[5] = '{12'h300, 32'hFFFFFFFF, 4'hF, 32'h00000000, 1'b1};
    rows[6] = '{scg_pkg::PWR_MODE_OFS, 32'hFFFFFFFF, 4'hF, 32'h00041030,
                1'b0};
    repeat (3) @(posedge pclk);
    chk({31'h0, pready}, 32'h1, "pready in reset");
    presetn <= 1'b1;
    chk(gw, 32'h0, "gates after reset");
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, rows[i].a, 32'h0, 4'hF, rd, er);
      chk(rd, 32'h0, "reset value");
    end
    $display("reset test done");
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d, rows[i].s, rd, er);
      chk({31'h0, er}, {31'h0, rows[i].e}, "write fault");
      settle();
      apb(1'b0, rows[i].a, 32'h0, 4'hF, rd, er);
      chk(rd, rows[i].r, "read back");
      chk({31'h0, er}, {31'h0, rows[i].e}, "read fault");
    end
    $display("table test done");
    deep_req <= 1'b1;
    foreach (bits[i])
    begin
      apb(1'b1, scg_pkg::DEEP_GATE_OFS, 32'h1 << bits[i], 4'hF, rd, er);
      settle();
      chk(gw, 32'h1 << bits[i], "deep gate bit");
    end
    apb(1'b1, scg_pkg::DEEP_GATE_OFS, 32'h00000001, 4'hF, rd, er);
    settle();
    for (int i = 0; i < 2; i++)
    begin
      @(posedge pclk);
      periph_access <= 1'b1;
      periph_sel <= 32'h1 << i;
      @(posedge pclk);
      periph_access <= 1'b0;
      #1;
      chk({31'h0, periph_fault}, {31'h0, i == 1}, "fault");
    end
    $display("deep test done");
    apb(1'b1, scg_pkg::SLEEP_GATE_OFS, 32'h00000010, 4'hF, rd, er);
    @(posedge pclk);
    deep_req <= 1'b0;
    sleep_req <= 1'b1;
    settle();
    chk(gw, 32'h00000010, "sleep gates");
    apb(1'b1, scg_pkg::RUN_CFG_OFS, 32'h0, 4'hF, rd, er);
    settle();
    chk(gw, 32'h00041030, "run gates in sleep");
    @(posedge pclk);
    deep_req <= 1'b1;
    settle();
    chk(gw, 32'h00041030, "run gates in deep");
    $display("mode test done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk(gw, 32'h0, "gates in reset");
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, scg_pkg::DEEP_GATE_OFS, 32'h0, 4'hF, rd, er);
    chk(rd, 32'h0, "deep after reset");
    $display("second reset test done");
    end_sim();
  end
endmodule : scg_gate_tb_top
